// *** verilog/wiper_ctrl_pkg.sv ***
// package for the up/down wiper host controller
// assumes a 250 MHz system clock driving the controller
`default_nettype none
package wiper_ctrl_pkg;
  // clock rate
  localparam int unsigned CLK_MHZ = 250;
  // wiper range
  localparam int unsigned TAP_COUNT = 64;
  localparam int unsigned TAP_W = 6;
  localparam logic [5:0] TAP_MIDSCALE = 6'h1F;
  // step timing, ns, and cycle counts (least times round up)
  localparam int unsigned STEP_HIGH_NS = 100;
  localparam int unsigned STEP_LOW_NS = 100;
  localparam int unsigned STEP_HIGH_CYC = (STEP_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned STEP_LOW_CYC = (STEP_LOW_NS * CLK_MHZ + 999) / 1000;
  // programming timing, ms, and cycle counts
  localparam int unsigned SUPPLY_TO_SEL_MS = 1;
  localparam int unsigned SEL_TO_SUPPLY_OFF_MS = 5;
  localparam int unsigned PROGRAM_PULSE_LOW_MS = 5;
  localparam int unsigned PROGRAM_PULSE_HIGH_MS = 5;
  localparam int unsigned SUPPLY_OFF_TO_SEL_MS = 1;
  localparam int unsigned SUPPLY_TO_SEL_CYC = SUPPLY_TO_SEL_MS * CLK_MHZ * 1000;
  localparam int unsigned SEL_TO_SUPPLY_OFF_CYC =
    SEL_TO_SUPPLY_OFF_MS * CLK_MHZ * 1000;
  localparam int unsigned PROGRAM_PULSE_LOW_CYC =
    PROGRAM_PULSE_LOW_MS * CLK_MHZ * 1000;
  localparam int unsigned PROGRAM_PULSE_HIGH_CYC =
    PROGRAM_PULSE_HIGH_MS * CLK_MHZ * 1000;
  localparam int unsigned SUPPLY_OFF_TO_SEL_CYC =
    SUPPLY_OFF_TO_SEL_MS * CLK_MHZ * 1000;
  // pulse counts for storing and for locking
  localparam logic [2:0] PULSES_STORE = 3'h6;
  localparam logic [2:0] PULSES_LOCK = 3'h7;
  // user command
  typedef struct packed {
    logic up;           // direction of a step burst
    logic [5:0] steps;  // taps to move, 0 means none
  } step_cmd_type;
endpackage
`default_nettype wire

// *** verilog/wiper_ctrl.sv ***
// host controller driving an up/down wiper part via select and step pins
// assumes synchronous user inputs and the part powered before use
`default_nettype none

// Functional notes
// RULE1: part has 64 taps; host tracks its wiper in 0..63
// RULE2: part reacts to step edges only while select is low
// RULE3: select falling edge latches direction from step pin level
// RULE4: each step rising edge with select low moves one tap
// RULE5: direction holds until the next select falling edge
// RULE6: step low at select rise gives one extra tap
// RULE7: step high at select rise gives no move; then wiper holds
// RULE8: host idles step high so select rise adds no step
// RULE9: increments at top tap leave wiper unchanged
// RULE10: decrements at bottom tap leave wiper unchanged
// RULE11: unprogrammed part powers up at tap 31, adjustable
// RULE12: unlocked programmed part loads stored tap, stays adjustable
// RULE13: program: set tap, step and select high, supply on, select low
// RULE14: each pulse is select high then low for the minimum times
// RULE15: six pulses with supply store the tap, wiper stays adjustable
// RULE16: seven pulses also lock; locked part ignores both pins
// RULE17: host removes supply before raising select to end
// RULE18: after six pulses programming may be entered again
// RULE19: repeated programming ORs new code into stored code
// RULE20: supply presence is a digital qualifier; no pulses when locked
// RULE21: over seven pulses ignored; under six changes nothing
module wiper_ctrl #(
  parameter int unsigned SUPPLY_TO_SEL_CYC =
    wiper_ctrl_pkg::SUPPLY_TO_SEL_CYC,
  parameter int unsigned SEL_TO_SUPPLY_OFF_CYC =
    wiper_ctrl_pkg::SEL_TO_SUPPLY_OFF_CYC,
  parameter int unsigned PROGRAM_PULSE_LOW_CYC =
    wiper_ctrl_pkg::PROGRAM_PULSE_LOW_CYC,
  parameter int unsigned PROGRAM_PULSE_HIGH_CYC =
    wiper_ctrl_pkg::PROGRAM_PULSE_HIGH_CYC,
  parameter int unsigned SUPPLY_OFF_TO_SEL_CYC =
    wiper_ctrl_pkg::SUPPLY_OFF_TO_SEL_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // step command
  input wire logic step_valid,
  input wire wiper_ctrl_pkg::step_cmd_type step_cmd,
  output logic step_ready,
  // programming command
  input wire logic program_valid,
  input wire logic program_lock,
  output logic program_ready,
  // status
  input wire logic [5:0] boot_tap,
  input wire logic boot_locked,
  output logic [5:0] wiper_tap,
  output logic locked,
  output logic busy,
  // device pins
  output logic select_n,
  output logic step_dir,
  output logic program_supply
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    IDLE, S_DIR, S_SEL, S_LOW, S_HIGH, S_END,
    P_SUPPLY, P_SEL, P_HIGH, P_LOW, P_HOLD, P_OFF, P_END
  } state_type;

  state_type state;
  state_type next_state;
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic [5:0] remain;
  logic [5:0] next_remain;
  logic dir_up;
  logic [2:0] pulses;
  logic [2:0] next_pulses;
  logic lock_req;
  logic boot_seen;

  // ---------------------------------------------------------------
  // decoding
  // ---------------------------------------------------------------
  // timer expiry and saturating tap arithmetic
  wire timer_done = (timer == 32'h0);
  wire at_top = (wiper_tap == 6'h3F);                        // RULE1
  wire at_bottom = (wiper_tap == 6'h00);
  wire [5:0] tap_up = at_top ? wiper_tap : wiper_tap + 6'h01;     // RULE9
  wire [5:0] tap_down = at_bottom ? wiper_tap : wiper_tap - 6'h01; // RULE10
  wire [5:0] tap_next = dir_up ? tap_up : tap_down;            // RULE5
  wire [2:0] pulse_target = lock_req ? wiper_ctrl_pkg::PULSES_LOCK
                                     : wiper_ctrl_pkg::PULSES_STORE;
  // handshakes: a locked part takes no orders
  assign step_ready = (state == IDLE) && !locked && boot_seen; // RULE16
  assign program_ready = step_ready;                           // RULE20
  assign busy = (state != IDLE) || !boot_seen;

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  // next state, timer and counters
  always_comb
  begin
    next_state = state;
    next_timer = timer_done ? 32'h0 : timer - 32'h1;
    next_remain = remain;
    next_pulses = pulses;
    case (state)
      IDLE:
      begin
        if (step_ready && step_valid && step_cmd.steps != 6'h00)
        begin
          next_state = S_DIR;
          next_remain = step_cmd.steps;
          next_timer = wiper_ctrl_pkg::STEP_HIGH_CYC;
        end
        else if (program_ready && program_valid)
        begin
          next_state = P_SUPPLY;                               // RULE13
          next_pulses = 3'h0;
          next_timer = SUPPLY_TO_SEL_CYC;
        end
      end
      // direction set up on step pin, then select falls
      S_DIR:
        if (timer_done)
        begin
          next_state = S_SEL;
          next_timer = wiper_ctrl_pkg::STEP_HIGH_CYC;
        end
      S_SEL:
        if (timer_done)
        begin
          next_state = S_LOW;
          next_timer = wiper_ctrl_pkg::STEP_LOW_CYC;
        end
      S_LOW:
        if (timer_done)
        begin
          next_state = S_HIGH;                                 // RULE4
          next_remain = remain - 6'h01;
          next_timer = wiper_ctrl_pkg::STEP_HIGH_CYC;
        end
      S_HIGH:
        if (timer_done)
        begin
          if (remain == 6'h00)
          begin
            next_state = S_END;
            next_timer = wiper_ctrl_pkg::STEP_HIGH_CYC;
          end
          else
          begin
            next_state = S_LOW;
            next_timer = wiper_ctrl_pkg::STEP_LOW_CYC;
          end
        end
      S_END:
        if (timer_done)
          next_state = IDLE;
      P_SUPPLY:
        if (timer_done)
        begin
          next_state = P_SEL;
          next_timer = PROGRAM_PULSE_LOW_CYC;
        end
      P_SEL:
        if (timer_done)
        begin
          next_state = P_HIGH;                                 // RULE14
          next_timer = PROGRAM_PULSE_HIGH_CYC;
        end
      P_HIGH:
        if (timer_done)
        begin
          next_state = P_LOW;
          next_pulses = pulses + 3'h1;
          next_timer = PROGRAM_PULSE_LOW_CYC;
        end
      P_LOW:
        if (timer_done)
        begin
          if (pulses == pulse_target)                          // RULE15
          begin
            next_state = P_HOLD;
            next_timer = SEL_TO_SUPPLY_OFF_CYC;
          end
          else
          begin
            next_state = P_HIGH;
            next_timer = PROGRAM_PULSE_HIGH_CYC;
          end
        end
      P_HOLD:
        if (timer_done)
        begin
          next_state = P_OFF;                                  // RULE17
          next_timer = SUPPLY_OFF_TO_SEL_CYC;
        end
      P_OFF:
        if (timer_done)
          next_state = P_END;
      P_END:
        next_state = IDLE;                                     // RULE18
      default:
        next_state = IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= IDLE;
      timer <= 32'h0;
      remain <= 6'h00;
      pulses <= 3'h0;
    end
    else
    begin
      state <= next_state;
      timer <= next_timer;
      remain <= next_remain;
      pulses <= next_pulses;
    end
  end

  // ---------------------------------------------------------------
  // pins and wiper tracking
  // ---------------------------------------------------------------
  // boot value caught after reset release; direction and lock latched
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      boot_seen <= 1'b0;
      wiper_tap <= wiper_ctrl_pkg::TAP_MIDSCALE;               // RULE11
      locked <= 1'b0;
      dir_up <= 1'b1;
      lock_req <= 1'b0;
      select_n <= 1'b1;
      step_dir <= 1'b1;                                        // RULE8
      program_supply <= 1'b0;
    end
    else
    begin
      if (!boot_seen)
      begin
        boot_seen <= 1'b1;
        wiper_tap <= boot_tap;                                 // RULE12
        locked <= boot_locked;
      end
      if (state == IDLE && next_state == S_DIR)
      begin
        dir_up <= step_cmd.up;
        step_dir <= step_cmd.up;
      end
      if (state == IDLE && next_state == P_SUPPLY)
      begin
        lock_req <= program_lock;
        program_supply <= 1'b1;                                // RULE20
      end
      if (state == S_DIR && timer_done)
        select_n <= 1'b0;                                      // RULE3
      // step pin falls before every step, the first and each later one
      if (state == S_SEL && timer_done)
        step_dir <= 1'b0;
      if (state == S_HIGH && timer_done && remain != 6'h00)
        step_dir <= 1'b0;                                      // RULE4
      if (state == S_LOW && timer_done)
      begin
        step_dir <= 1'b1;                                      // RULE2
        wiper_tap <= tap_next;
      end
      if (state == S_END && timer_done)
        select_n <= 1'b1;                                      // RULE7
      if (state == P_SUPPLY && timer_done)
        select_n <= 1'b0;
      if (state == P_SEL && timer_done)
        select_n <= 1'b1;
      // no rise after the last pulse: select stays low past supply off
      if (state == P_LOW && timer_done && pulses != pulse_target)
        select_n <= 1'b1;                                      // RULE15
      if (state == P_HIGH && timer_done)
        select_n <= 1'b0;
      if (state == P_HOLD && timer_done)
        program_supply <= 1'b0;
      if (state == P_OFF && timer_done)
        select_n <= 1'b1;
      if (state == P_END && lock_req)
        locked <= 1'b1;                                        // RULE16
    end
  end
endmodule
`default_nettype wire

// *** sim/wiper_ctrl_monitor.sv ***
// port assertions for the wiper host controller
// assumes binding to every wiper_ctrl instance
`default_nettype none
module wiper_ctrl_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // commands
  input wire logic step_valid,
  input wire wiper_ctrl_pkg::step_cmd_type step_cmd,
  input wire logic step_ready,
  input wire logic program_ready,
  // status and pins
  input wire logic [5:0] wiper_tap,
  input wire logic locked,
  input wire logic busy,
  input wire logic select_n,
  input wire logic step_dir,
  input wire logic program_supply
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----
  // helpers
  // ----
  // select rises counted while the programming supply is on
  logic select_was;
  logic supply_was;
  logic [3:0] rise_count;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      select_was <= 1'b1;
      supply_was <= 1'b0;
      rise_count <= 4'h0;
    end
    else
    begin
      select_was <= select_n;
      supply_was <= program_supply;
      if (program_supply && !supply_was)
        rise_count <= 4'h0;
      else if (program_supply && select_n && !select_was)
        rise_count <= rise_count + 4'h1;
    end
  end
  // ----
  // sequences
  // ----
  sequence tap_moved;
    $changed(wiper_tap) && $past(resetn, 2);
  endsequence
  sequence step_edge;
    $rose(step_dir) && !select_n;
  endsequence
  // ----
  // checks
  // ----
  idle_pins_a: assert property (step_ready |-> select_n && step_dir)
    else $error("idle pins wrong");
  sel_rise_a: assert property ($rose(select_n) |-> step_dir)
    else $error("select rose with step low");
  dir_hold_a: assert property ($fell(select_n) |-> $stable(step_dir))
    else $error("step moved at select fall");
  tap_step_a: assert property (tap_moved |-> step_edge)
    else $error("tap moved without step");
  tap_unit_a: assert property (tap_moved |->
    {1'b0, wiper_tap} == {1'b0, $past(wiper_tap)} + 7'h01 ||
    {1'b0, wiper_tap} == {1'b0, $past(wiper_tap)} - 7'h01)
    else $error("tap moved by more than one");
  supply_on_a: assert property ($rose(program_supply) |-> select_n)
    else $error("supply on with select low");
  supply_dir_a: assert property (program_supply |-> step_dir)
    else $error("step low while programming");
  supply_off_a: assert property ($fell(program_supply) |-> !select_n)
    else $error("select rose before supply off");
  take_busy_a: assert property (step_valid && step_ready &&
    step_cmd.steps != 6'h00 |=> busy && !step_ready)
    else $error("step command not taken");
  lock_block_a: assert property (locked |-> !step_ready && !program_ready)
    else $error("locked yet ready");
  pulse_count_a: assert property ($fell(program_supply) |->
    rise_count == 4'h6 || rise_count == 4'h7)
    else $error("wrong number of program pulses");
endmodule
bind wiper_ctrl wiper_ctrl_monitor MON (.clk(clk), .resetn(resetn),
  .step_valid(step_valid), .step_cmd(step_cmd), .step_ready(step_ready),
  .program_ready(program_ready), .wiper_tap(wiper_tap), .locked(locked),
  .busy(busy), .select_n(select_n), .step_dir(step_dir),
  .program_supply(program_supply));
`default_nettype wire

// *** sim/wiper_device_model.sv ***
// behavioural up/down wiper part with one-time programming
// assumes its pins come from the host controller; no clock
`default_nettype none
module wiper_device_model (
  // device pins
  input wire logic select_n,
  input wire logic step_dir,
  input wire logic program_supply,
  // power-on state
  output logic [5:0] boot,
  output logic lock
);
  logic [5:0] tap = 6'h1F;
  logic [5:0] stored = 6'h00;
  logic done = 1'b0;
  logic up = 1'b1;
  int pulses = 0;
  initial boot = 6'h1F;
  initial lock = 1'b0;
  // power-up load of stored or midscale tap
  task automatic power_up();
    boot = done ? stored : 6'h1F;
    tap = boot;
  endtask
  // saturating one-tap move
  task automatic move();
    if (up && tap != 6'h3F) tap = tap + 6'h01;
    if (!up && tap != 6'h00) tap = tap - 6'h01;
  endtask
  // direction latch, steps and pulse count, dead once locked
  always @(negedge select_n)
    if (!lock) up = step_dir;
  always @(posedge step_dir)
    if (!lock && select_n === 1'b0) move();
  always @(posedge select_n)
  begin
    if (!lock && step_dir === 1'b0) move();
    if (!lock && program_supply === 1'b1 && pulses < 7) pulses++;
  end
  // otp store as the supply goes away
  always @(posedge program_supply) pulses = 0;
  always @(negedge program_supply)
    if (!lock && pulses >= 6)
    begin
      stored = stored | tap;
      done = 1'b1;
      lock = pulses == 7;
    end
endmodule
`default_nettype wire

// *** sim/wiper_ctrl_tb.sv ***
// self-checking bench for the wiper host controller and part model
// assumes shortened programming times of ten cycles
`default_nettype none
module wiper_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic step_valid = 1'b0;
  wiper_ctrl_pkg::step_cmd_type step_cmd = '0;
  logic program_valid = 1'b0;
  logic program_lock = 1'b0;
  logic step_ready, program_ready, locked, busy, boot_locked;
  logic select_n, step_dir, program_supply;
  logic [5:0] wiper_tap, boot_tap;
  int errors = 0;
  int samples_checked = 0;
  always #2 clk = ~clk;
  wiper_ctrl #(.SUPPLY_TO_SEL_CYC(10), .SEL_TO_SUPPLY_OFF_CYC(10),
    .PROGRAM_PULSE_LOW_CYC(10), .PROGRAM_PULSE_HIGH_CYC(10),
    .SUPPLY_OFF_TO_SEL_CYC(10)) DUT (.clk(clk), .resetn(resetn),
    .step_valid(step_valid), .step_cmd(step_cmd), .step_ready(step_ready),
    .program_valid(program_valid), .program_lock(program_lock),
    .program_ready(program_ready), .boot_tap(boot_tap),
    .boot_locked(boot_locked), .wiper_tap(wiper_tap), .locked(locked),
    .busy(busy), .select_n(select_n), .step_dir(step_dir),
    .program_supply(program_supply));
  wiper_device_model DEV (.select_n(select_n), .step_dir(step_dir),
    .program_supply(program_supply), .boot(boot_tap), .lock(boot_locked));
  // ----
  // helpers
  // ----
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      errors++;
    end
  endtask
  task automatic both(input logic [5:0] exp);
    chk(wiper_tap, exp);
    chk(DEV.tap, exp);
  endtask
  // power the part, reset the controller
  task automatic power();
    DEV.power_up();
    resetn = 1'b0;
    repeat (6) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // one command, then wait bounded for idle
  task automatic issue(input logic s, input logic u, input logic [5:0] n,
    input logic lk);
    int i;
    step_valid = s;
    program_valid = !s;
    step_cmd.up = u;
    step_cmd.steps = n;
    program_lock = lk;
    @(posedge clk);
    #1 step_valid = 1'b0;
    program_valid = 1'b0;
    for (i = 0; i < 9000 && busy !== 1'b0; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (i == 9000)
    begin
      $display("[FAIL] t=%0t busy got %h exp %h", $time, busy, 1'b0);
      errors++;
      complete_run();
    end
    else
      repeat (2) @(posedge clk);
    #1;
  endtask
  // ----
  // scenarios
  // ----
  task automatic test_reset();
    power();
    both(6'h1F);
    chk({5'h00, locked}, 6'h00);
    $display("test reset done");
  endtask
  task automatic test_steps();
    issue(1'b1, 1'b1, 6'h05, 1'b0);
    both(6'h24);
    issue(1'b1, 1'b0, 6'h28, 1'b0);
    both(6'h00);
    issue(1'b1, 1'b1, 6'h3F, 1'b0);
    issue(1'b1, 1'b1, 6'h01, 1'b0);
    both(6'h3F);
    issue(1'b1, 1'b0, 6'h2A, 1'b0);
    both(6'h15);
    $display("test steps done");
  endtask
  task automatic test_program();
    issue(1'b0, 1'b0, 6'h00, 1'b0);
    chk(DEV.stored, 6'h15);
    power();
    both(6'h15);
    issue(1'b1, 1'b1, 6'h01, 1'b0);
    both(6'h16);
    issue(1'b0, 1'b0, 6'h00, 1'b0);
    power();
    both(6'h17);
    $display("test program done");
  endtask
  task automatic test_lock();
    issue(1'b0, 1'b0, 6'h00, 1'b1);
    chk({5'h00, locked}, 6'h01);
    issue(1'b1, 1'b0, 6'h03, 1'b0);
    both(6'h17);
    power();
    chk({5'h00, locked}, 6'h01);
    $display("test lock done");
  endtask
  initial
  begin
    test_reset();
    test_steps();
    test_program();
    test_lock();
    complete_run();
  end
endmodule
`default_nettype wire
